// ### logic/icsc_top.v
`include "icsc_regs.vh"

module icsc_top #(
    parameter MS_CYCLES = `ICSC_MS_NS / `ICSC_CLK_NS
) (
    // Clock and reset.
    input wire CLK,
    input wire RSTN,
    // Avalon-MM slave.
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // Pins.
    input wire FORWARD_RUN,
    input wire REVERSE_RUN,
    input wire STOP_KEY,
    input wire CAP_SMALL_200V,
    // Measured output current in percent of rating.
    input wire [8:0] OUTPUT_CURRENT,
    // Drive outputs.
    output reg [15:0] OUTPUT_FREQ,
    output reg OUTPUT_ON,
    output reg DC_BRAKE,
    output reg [7:0] DC_BRAKE_LEVEL,
    output reg [7:0] CARRIER_KHZ10,
    output reg [5:0] CARRIER_MULT,
    output reg STOP_ALARM,
    output reg IRQ
);
    localparam ST_STOP = 2'b00;
    localparam ST_RUN = 2'b01;
    localparam ST_DECEL = 2'b10;
    localparam ST_BRAKE = 2'b11;

    reg [`ICSC_CTRL_W-1:0] ctrl_reg;
    reg [15:0] fref_reg;
    reg [15:0] minf_reg;
    reg [15:0] decel_reg;
    reg [15:0] dcbrk_reg;
    reg [15:0] fmax_reg;
    reg [`ICSC_IRQ_W-1:0] istat_reg;
    reg [`ICSC_IRQ_W-1:0] imask_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] fout_reg;
    reg [15:0] fout_next;
    reg [31:0] acc_reg;
    reg [31:0] acc_next;
    reg [7:0] brk_cnt_reg;
    reg [7:0] brk_cnt_next;
    reg stop_latch_reg;
    reg stop_key_d_reg;
    reg blink_reg;
    reg car_red_reg;
    reg [1:0] init_cnt_reg;
    reg [`ICSC_IRQ_W-1:0] ev;
    wire [2:0] pins_s;
    wire cap_s;
    wire tick_ms;
    wire tick_100ms;
    wire fwd_s = pins_s[0];
    wire rev_s = pins_s[1];
    wire key_s = pins_s[2];
    wire [3:0] car_sel = ctrl_reg[`ICSC_CTRL_CAR];
    wire coast = ctrl_reg[`ICSC_CTRL_SMETH];
    wire term_cmd = fwd_s | rev_s;
    wire comm_cmd = ctrl_reg[`ICSC_CTRL_CRUN];
    wire src_cmd = ctrl_reg[`ICSC_CTRL_SRC] ? comm_cmd : term_cmd;
    wire running = state_reg != ST_STOP;
    wire key_press = key_s & ~stop_key_d_reg;
    wire key_stop = key_press & running &
        ~ctrl_reg[`ICSC_CTRL_SKEY];
    wire latch_clr = ~src_cmd;
    wire run_cmd = src_cmd & ~stop_latch_reg & ~key_stop;
    wire fref_low = fref_reg < minf_reg;
    wire [7:0] brk_time = dcbrk_reg[`ICSC_BRK_TIME];
    wire [31:0] decel_div = {16'h0000, decel_reg} * `ICSC_DECEL_PER_MS;
    wire car_red_cond = ctrl_reg[`ICSC_CTRL_LSCR] &
        (fout_reg <= `ICSC_LS_FOUT) &
        (OUTPUT_CURRENT >= `ICSC_LS_CUR);
    wire bus_req = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
    wire wr_take = AVS_WRITE & ~AVS_WAITREQUEST;
    wire [31:0] wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
        {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wire [31:0] wbits = AVS_WRITEDATA & wmask;

    icsc_sync #(
        .W(3)
    ) u_pin_sync (
        .CLK(CLK),
        .RSTN(RSTN),
        .d({STOP_KEY, REVERSE_RUN, FORWARD_RUN}),
        .q(pins_s)
    );

    icsc_sync #(
        .W(1)
    ) u_cap_sync (
        .CLK(CLK),
        .RSTN(RSTN),
        .d(CAP_SMALL_200V),
        .q(cap_s)
    );

    icsc_tick #(
        .DIV(MS_CYCLES)
    ) u_ms_tick (
        .CLK(CLK),
        .RSTN(RSTN),
        .en(1'b1),
        .pulse(tick_ms)
    );

    icsc_tick #(
        .DIV(`ICSC_BRK_STEP_MS)
    ) u_brk_tick (
        .CLK(CLK),
        .RSTN(RSTN),
        .en(tick_ms),
        .pulse(tick_100ms)
    );

    // Frequency ramp and stop sequence.
    always @* begin
        state_next = state_reg;
        fout_next = fout_reg;
        acc_next = acc_reg;
        brk_cnt_next = brk_cnt_reg;
        ev = {`ICSC_IRQ_W{1'b0}};
        ev[`ICSC_IRQ_KEYSTOP] = key_stop;
        case (state_reg)
            ST_STOP: begin
                acc_next = 32'h0000_0000;
                if (run_cmd && !fref_low) begin
                    state_next = ST_RUN;
                    fout_next = minf_reg;
                end
            end
            ST_RUN: begin
                if (!run_cmd && coast) begin
                    state_next = ST_STOP;
                    fout_next = 16'h0000;
                    ev[`ICSC_IRQ_STOPPED] = 1'b1;
                end else if (!run_cmd || fref_low) begin
                    state_next = ST_DECEL;
                end else if (tick_ms) begin
                    if (fout_reg < fref_reg) begin
                        fout_next = fout_reg + 16'h0001;
                    end else if (fout_reg > fref_reg) begin
                        fout_next = fout_reg - 16'h0001;
                    end
                end
            end
            ST_DECEL: begin
                if (run_cmd && !fref_low) begin
                    state_next = ST_RUN;
                end else if (fout_reg <= minf_reg) begin
                    // Braking begins where the ramp meets the minimum.
                    if (brk_time == 8'h00 || coast) begin
                        state_next = ST_STOP;
                        fout_next = 16'h0000;
                        ev[`ICSC_IRQ_STOPPED] = 1'b1;
                    end else begin
                        state_next = ST_BRAKE;
                        brk_cnt_next = brk_time;
                        ev[`ICSC_IRQ_BRAKE] = 1'b1;
                    end
                end else if (tick_ms) begin
                    // Slope is fmax per decel time in 0.1 s units.
                    acc_next = acc_reg + {16'h0000, fmax_reg};
                    if (acc_next >= decel_div) begin
                        acc_next = acc_next - decel_div;
                        fout_next = fout_reg - 16'h0001;
                    end
                end
            end
            ST_BRAKE: begin
                fout_next = 16'h0000;
                if (tick_100ms) begin
                    if (brk_cnt_reg <= 8'h01) begin
                        state_next = ST_STOP;
                        ev[`ICSC_IRQ_STOPPED] = 1'b1;
                    end else begin
                        brk_cnt_next = brk_cnt_reg - 8'h01;
                    end
                end
            end
            default: begin
                state_next = ST_STOP;
                fout_next = 16'h0000;
            end
        endcase
        ev[`ICSC_IRQ_CARRED] = car_red_cond & ~car_red_reg;
    end

    always @(posedge CLK) begin
        if (!RSTN) begin
            state_reg <= ST_STOP;
            fout_reg <= 16'h0000;
            acc_reg <= 32'h0000_0000;
            brk_cnt_reg <= 8'h00;
            stop_latch_reg <= 1'b0;
            stop_key_d_reg <= 1'b0;
            blink_reg <= 1'b0;
            car_red_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fout_reg <= fout_next;
            acc_reg <= acc_next;
            brk_cnt_reg <= brk_cnt_next;
            stop_key_d_reg <= key_s;
            car_red_reg <= car_red_cond;
            if (key_stop) begin
                stop_latch_reg <= 1'b1;
            end else if (latch_clr) begin
                stop_latch_reg <= 1'b0;
            end
            if (tick_100ms) begin
                blink_reg <= ~blink_reg;
            end
        end
    end

    // Carrier selection and drive outputs.
    always @(posedge CLK) begin
        if (!RSTN) begin
            OUTPUT_FREQ <= 16'h0000;
            OUTPUT_ON <= 1'b0;
            DC_BRAKE <= 1'b0;
            DC_BRAKE_LEVEL <= 8'h00;
            CARRIER_KHZ10 <= `ICSC_KHZ_7K5;
            CARRIER_MULT <= 6'h00;
            STOP_ALARM <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            OUTPUT_FREQ <= fout_reg;
            OUTPUT_ON <= state_reg != ST_STOP;
            DC_BRAKE <= state_reg == ST_BRAKE;
            DC_BRAKE_LEVEL <= (state_reg == ST_BRAKE) ?
                dcbrk_reg[`ICSC_BRK_CUR] : 8'h00;
            STOP_ALARM <= stop_latch_reg & blink_reg;
            IRQ <= |(istat_reg & imask_reg);
            CARRIER_MULT <= 6'h00;
            if (car_red_cond) begin
                CARRIER_KHZ10 <= `ICSC_KHZ_2K5;
            end else begin
                case (car_sel)
                    `ICSC_CAR_2K5: CARRIER_KHZ10 <= `ICSC_KHZ_2K5;
                    `ICSC_CAR_5K0: CARRIER_KHZ10 <= `ICSC_KHZ_5K0;
                    `ICSC_CAR_7K5: CARRIER_KHZ10 <= `ICSC_KHZ_7K5;
                    `ICSC_CAR_10K: CARRIER_KHZ10 <= `ICSC_KHZ_10K;
                    `ICSC_CAR_12F: begin
                        CARRIER_KHZ10 <= 8'h00;
                        CARRIER_MULT <= `ICSC_MUL_12;
                    end
                    `ICSC_CAR_24F: begin
                        CARRIER_KHZ10 <= 8'h00;
                        CARRIER_MULT <= `ICSC_MUL_24;
                    end
                    `ICSC_CAR_36F: begin
                        CARRIER_KHZ10 <= 8'h00;
                        CARRIER_MULT <= `ICSC_MUL_36;
                    end
                    default: CARRIER_MULT <= CARRIER_MULT;
                endcase
            end
        end
    end

    // Avalon-MM slave: one wait state, then the transfer completes.
    always @(posedge CLK) begin
        if (!RSTN) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            AVS_WAITREQUEST <= ~bus_req;
            if (bus_req && AVS_READ) begin
                case (AVS_ADDRESS)
                    `ICSC_A_CTRL: AVS_READDATA <= {23'h00_0000, ctrl_reg};
                    `ICSC_A_FREF: AVS_READDATA <= {16'h0000, fref_reg};
                    `ICSC_A_MINF: AVS_READDATA <= {16'h0000, minf_reg};
                    `ICSC_A_DECEL: AVS_READDATA <= {16'h0000, decel_reg};
                    `ICSC_A_DCBRK: AVS_READDATA <= {16'h0000, dcbrk_reg};
                    `ICSC_A_STATUS: AVS_READDATA <= {fout_reg, 10'h000,
                        car_red_reg, state_reg == ST_BRAKE, running,
                        stop_latch_reg, state_reg};
                    `ICSC_A_ISTAT: AVS_READDATA <= {28'h000_0000, istat_reg};
                    `ICSC_A_IMASK: AVS_READDATA <= {28'h000_0000, imask_reg};
                    `ICSC_A_FMAX: AVS_READDATA <= {16'h0000, fmax_reg};
                    default: AVS_READDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Register file; the default carrier is loaded once the strap is stable.
    always @(posedge CLK) begin
        if (!RSTN) begin
            ctrl_reg <= `ICSC_RST_CTRL;
            fref_reg <= `ICSC_RST_FREF;
            minf_reg <= `ICSC_RST_MINF;
            decel_reg <= `ICSC_RST_DECEL;
            dcbrk_reg <= `ICSC_RST_DCBRK;
            fmax_reg <= `ICSC_RST_FMAX;
            istat_reg <= {`ICSC_IRQ_W{1'b0}};
            imask_reg <= {`ICSC_IRQ_W{1'b0}};
            init_cnt_reg <= 2'b00;
        end else begin
            if (init_cnt_reg != 2'b11) begin
                init_cnt_reg <= init_cnt_reg + 2'b01;
            end
            if (init_cnt_reg == 2'b10) begin
                ctrl_reg[`ICSC_CTRL_CAR] <= cap_s ?
                    `ICSC_CAR_10K : `ICSC_CAR_7K5;
            end else if (wr_take && AVS_ADDRESS == `ICSC_A_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~wmask[`ICSC_CTRL_W-1:0]) |
                    wbits[`ICSC_CTRL_W-1:0];
            end
            if (wr_take) begin
                case (AVS_ADDRESS)
                    `ICSC_A_FREF: fref_reg <= (fref_reg & ~wmask[15:0]) |
                        wbits[15:0];
                    `ICSC_A_MINF: minf_reg <= (minf_reg & ~wmask[15:0]) |
                        wbits[15:0];
                    `ICSC_A_DECEL: decel_reg <= (decel_reg & ~wmask[15:0]) |
                        wbits[15:0];
                    `ICSC_A_DCBRK: dcbrk_reg <= (dcbrk_reg & ~wmask[15:0]) |
                        wbits[15:0];
                    `ICSC_A_FMAX: fmax_reg <= (fmax_reg & ~wmask[15:0]) |
                        wbits[15:0];
                    `ICSC_A_IMASK: imask_reg <= wbits[`ICSC_IRQ_W-1:0];
                    default: ;
                endcase
            end
            // New events win over a write-one clear in the same cycle.
            if (wr_take && AVS_ADDRESS == `ICSC_A_ISTAT) begin
                istat_reg <= (istat_reg & ~wbits[`ICSC_IRQ_W-1:0]) | ev;
            end else begin
                istat_reg <= istat_reg | ev;
            end
        end
    end
endmodule

// ### logic/icsc_regs.vh
`ifndef ICSC_REGS_VH
`define ICSC_REGS_VH

// Register word addresses.
`define ICSC_A_CTRL 4'h0
`define ICSC_A_FREF 4'h1
`define ICSC_A_MINF 4'h2
`define ICSC_A_DECEL 4'h3
`define ICSC_A_DCBRK 4'h4
`define ICSC_A_STATUS 4'h5
`define ICSC_A_ISTAT 4'h6
`define ICSC_A_IMASK 4'h7
`define ICSC_A_FMAX 4'h8

// Control register fields.
`define ICSC_CTRL_CAR 3:0
`define ICSC_CTRL_LSCR 4
`define ICSC_CTRL_SKEY 5
`define ICSC_CTRL_SMETH 6
`define ICSC_CTRL_SRC 7
`define ICSC_CTRL_CRUN 8
`define ICSC_CTRL_W 9

// Brake register fields.
`define ICSC_BRK_CUR 7:0
`define ICSC_BRK_TIME 15:8

// Reset values.
`define ICSC_RST_CTRL 9'h000
`define ICSC_RST_FREF 16'h0000
`define ICSC_RST_MINF 16'h000F
`define ICSC_RST_DECEL 16'h0064
`define ICSC_RST_DCBRK 16'h0532
`define ICSC_RST_FMAX 16'h0258

// Carrier select codes.
`define ICSC_CAR_2K5 4'h1
`define ICSC_CAR_5K0 4'h2
`define ICSC_CAR_7K5 4'h3
`define ICSC_CAR_10K 4'h4
`define ICSC_CAR_12F 4'h7
`define ICSC_CAR_24F 4'h8
`define ICSC_CAR_36F 4'h9

// Carrier outputs: fixed frequency in 0.1 kHz, tracking multipliers.
`define ICSC_KHZ_2K5 8'h19
`define ICSC_KHZ_5K0 8'h32
`define ICSC_KHZ_7K5 8'h4B
`define ICSC_KHZ_10K 8'h64
`define ICSC_MUL_12 6'h0C
`define ICSC_MUL_24 6'h18
`define ICSC_MUL_36 6'h24

// Low speed carrier reduction: 5 Hz in 0.1 Hz units, 110 percent.
`define ICSC_LS_FOUT 16'h0032
`define ICSC_LS_CUR 9'h06E

// Timing.
`define ICSC_CLK_NS 40
`define ICSC_MS_NS 1000000
`define ICSC_BRK_STEP_MS 100
`define ICSC_DECEL_PER_MS 100

// Interrupt status bits.
`define ICSC_IRQ_KEYSTOP 0
`define ICSC_IRQ_STOPPED 1
`define ICSC_IRQ_BRAKE 2
`define ICSC_IRQ_CARRED 3
`define ICSC_IRQ_W 4

`endif

// ### logic/icsc_sync.v
module icsc_sync #(
    parameter W = 1
) (
    input wire CLK,
    input wire RSTN,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;

    always @(posedge CLK) begin
        if (!RSTN) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ### logic/icsc_tick.v
module icsc_tick #(
    parameter DIV = 100
) (
    input wire CLK,
    input wire RSTN,
    input wire en,
    output reg pulse
);
    reg [31:0] cnt_reg;

    always @(posedge CLK) begin
        if (!RSTN) begin
            cnt_reg <= 32'h0000_0000;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (en) begin
                if (cnt_reg >= DIV - 1) begin
                    cnt_reg <= 32'h0000_0000;
                    pulse <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                end
            end
        end
    end
endmodule

// ### dv/icsc_checker.sv
module icsc_checker #(
    parameter MS_CYCLES = 10
) (
    // Clock and reset.
    input wire CLK,
    input wire RSTN,
    // Bus writes.
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire AVS_WAITREQUEST,
    // Drive side.
    input wire CAP_SMALL_200V,
    input wire [8:0] OUTPUT_CURRENT,
    input wire [15:0] OUTPUT_FREQ,
    input wire OUTPUT_ON,
    input wire DC_BRAKE,
    input wire [7:0] DC_BRAKE_LEVEL,
    input wire [7:0] CARRIER_KHZ10,
    input wire [5:0] CARRIER_MULT
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shadows of settings; writes are assumed to use all byte lanes.
    reg [2:0] mode_reg;
    reg [7:0] cur_reg;
    reg [7:0] tim_reg;
    int brk_cnt;
    wire wr_done = AVS_WRITE && !AVS_WAITREQUEST;
    always @(posedge CLK) begin
        if (!RSTN) begin
            mode_reg <= 3'h0;
            cur_reg <= 8'h32;
            tim_reg <= 8'h05;
            brk_cnt <= 0;
        end else begin
            brk_cnt <= DC_BRAKE ? brk_cnt + 1 : 0;
            if (wr_done && AVS_ADDRESS == 4'h0)
                mode_reg <= AVS_WRITEDATA[6:4];
            if (wr_done && AVS_ADDRESS == 4'h4) begin
                cur_reg <= AVS_WRITEDATA[7:0];
                tim_reg <= AVS_WRITEDATA[15:8];
            end
        end
    end
    brake_level_a: assert property (@(posedge CLK) disable iff (!RSTN)
        DC_BRAKE && $past(DC_BRAKE) |-> DC_BRAKE_LEVEL == cur_reg)
        else $error("brake level differs from setting");
    idle_level_a: assert property (@(posedge CLK) disable iff (!RSTN)
        !DC_BRAKE && !$past(DC_BRAKE) |-> DC_BRAKE_LEVEL == 8'h00)
        else $error("brake level without braking");
    fixed_carrier_a: assert property (@(posedge CLK) disable iff (!RSTN)
        CARRIER_MULT == 6'h00 |-> CARRIER_KHZ10 inside {25, 50, 75, 100})
        else $error("fixed carrier value illegal");
    track_carrier_a: assert property (@(posedge CLK) disable iff (!RSTN)
        CARRIER_MULT != 6'h00 |-> CARRIER_KHZ10 == 8'h00
        && CARRIER_MULT inside {12, 24, 36})
        else $error("tracking carrier value illegal");
    low_speed_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_reg[0] && OUTPUT_ON && OUTPUT_FREQ <= 50
        && OUTPUT_CURRENT >= 110) [*4] |-> CARRIER_KHZ10 == 8'h19)
        else $error("carrier not reduced at low speed");
    coast_no_brake_a: assert property (@(posedge CLK)
        disable iff (!RSTN) mode_reg[2] [*3] |-> !$rose(DC_BRAKE))
        else $error("braking started in coast mode");
    zero_time_a: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(DC_BRAKE) |-> tim_reg != 8'h00)
        else $error("braking with zero brake time");
    brake_len_a: assert property (@(posedge CLK) disable iff (!RSTN)
        $fell(DC_BRAKE) |-> brk_cnt >= (tim_reg - 1) * 100 * MS_CYCLES
        && brk_cnt <= tim_reg * 100 * MS_CYCLES + 2)
        else $error("brake duration wrong");
    ramp_step_a: assert property (@(posedge CLK) disable iff (!RSTN)
        OUTPUT_ON && !DC_BRAKE && $past(OUTPUT_ON) && $past(OUTPUT_ON, 2)
        |-> OUTPUT_FREQ + 1 >= $past(OUTPUT_FREQ))
        else $error("output frequency dropped by more than a step");
    strap_default_a: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(RSTN) |-> ##8
        CARRIER_KHZ10 == (CAP_SMALL_200V ? 8'h64 : 8'h4B))
        else $error("default carrier wrong for capacity");
endmodule
bind icsc_top icsc_checker #(.MS_CYCLES(MS_CYCLES)) chk_i (.CLK(CLK),
    .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CAP_SMALL_200V(CAP_SMALL_200V), .OUTPUT_CURRENT(OUTPUT_CURRENT),
    .OUTPUT_FREQ(OUTPUT_FREQ), .OUTPUT_ON(OUTPUT_ON), .DC_BRAKE(DC_BRAKE),
    .DC_BRAKE_LEVEL(DC_BRAKE_LEVEL), .CARRIER_KHZ10(CARRIER_KHZ10),
    .CARRIER_MULT(CARRIER_MULT));

// ### dv/icsc_cmd_src.sv
// Terminals follow requests one edge late; the keypad holds a press.
module icsc_cmd_src (
    input wire clk,
    input wire fwd_req,
    input wire rev_req,
    input wire key_req,
    output logic fwd_run = 0,
    output logic rev_run = 0,
    output logic stop_key = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic key_d = 0;
    logic [3:0] hold = 4'h0;
    always @(posedge clk) begin
        fwd_run <= fwd_req;
        rev_run <= rev_req;
        key_d <= key_req;
        if (key_req && !key_d)
            hold <= 4'h8;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
        stop_key <= hold != 4'h0;
    end
endmodule

// ### dv/icsc_top_test.sv
module icsc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, rd = 0, wr = 0, cap = 1;
    logic fwd_req = 0, rev_req = 0, key_req = 0, saw_alm = 0;
    logic [3:0] addr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [8:0] cur = 0;
    wire [31:0] rdata;
    wire wait_r, forward_run, reverse_run, key, on, brk, alarm, irq;
    wire [15:0] fout;
    wire [7:0] lvl, khz;
    wire [5:0] mult;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, brk_cyc = 0, brk_mark = 0;
    always #20 clk = ~clk;
    icsc_top #(.MS_CYCLES(10)) uut (.CLK(clk), .RSTN(rstn),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
        .FORWARD_RUN(forward_run), .REVERSE_RUN(reverse_run), .STOP_KEY(key),
        .CAP_SMALL_200V(cap), .OUTPUT_CURRENT(cur), .OUTPUT_FREQ(fout),
        .OUTPUT_ON(on), .DC_BRAKE(brk), .DC_BRAKE_LEVEL(lvl),
        .CARRIER_KHZ10(khz), .CARRIER_MULT(mult), .STOP_ALARM(alarm),
        .IRQ(irq));
    icsc_cmd_src src (.clk(clk), .fwd_req(fwd_req), .rev_req(rev_req),
        .key_req(key_req), .fwd_run(forward_run), .rev_run(reverse_run), .stop_key(key));
    task final_report;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (brk === 1'b1)
            brk_cyc <= brk_cyc + 1;
        if (alarm === 1'b1)
            saw_alm <= 1;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        while (wait_r !== 1'b0)
            @(posedge clk);
        rdat = rdata;
        wr <= 0;
        rd <= 0;
    endtask
    task run_to(input logic [15:0] f);
        bus(1, 4'h1, {16'h0000, f});
        fwd_req <= 1;
        while (fout !== f)
            @(posedge clk);
    endtask
    task do_reset(input logic strap);
        rstn <= 0;
        cap <= strap;
        repeat (3) @(posedge clk);
        rstn <= 1;
        repeat (10) @(posedge clk);
    endtask
    task press;
        key_req <= 1;
        @(posedge clk);
        key_req <= 0;
    endtask
    initial begin
        do_reset(1);
        chk(khz, 32'h0000_0064);
        bus(0, 4'h4, 0);
        chk(rdat, 32'h0000_0532);
        bus(0, 4'hF, 0);
        chk(rdat, 0);
        // Codes 7 to 9 are legal here: no vector mode, short cable.
        for (int c = 1; c < 10; c++) begin
            if (c < 5 || c > 6) begin
                bus(1, 4'h0, c);
                repeat (4) @(posedge clk);
                chk(khz, c < 5 ? c * 25 : 0);
                chk(mult, c > 6 ? (c - 6) * 12 : 0);
            end
        end
        bus(1, 4'h3, 1);
        bus(1, 4'h4, 32'h0000_0132);
        bus(1, 4'h0, 3);
        bus(1, 4'h7, 6);
        run_to(25);
        fwd_req <= 0;
        while (brk !== 1'b1)
            @(posedge clk);
        @(posedge clk);
        chk(fout <= 15, 1);
        chk(lvl, 50);
        while (brk !== 1'b0)
            @(posedge clk);
        @(posedge clk);
        chk(on, 0);
        chk(irq, 1);
        bus(1, 4'h6, 32'h0000_000F);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        bus(1, 4'h4, 32'h0000_0032);
        run_to(25);
        brk_mark = brk_cyc;
        bus(1, 4'h1, 5);
        while (on !== 1'b0)
            @(posedge clk);
        chk(brk_cyc, brk_mark);
        bus(0, 4'h6, 0);
        chk(rdat, 32'h0000_0002);
        bus(1, 4'h6, 32'h0000_000F);
        fwd_req <= 0;
        bus(1, 4'h4, 32'h0000_0132);
        bus(1, 4'h0, 32'h0000_0043);
        run_to(25);
        brk_mark = brk_cyc;
        fwd_req <= 0;
        repeat (7) @(posedge clk);
        chk(on, 0);
        repeat (40) @(posedge clk);
        chk(brk_cyc, brk_mark);
        bus(1, 4'h0, 3);
        run_to(25);
        press;
        while (on !== 1'b0)
            @(posedge clk);
        repeat (20) @(posedge clk);
        chk(on, 0);
        chk(saw_alm, 1);
        bus(0, 4'h5, 0);
        chk(rdat[2], 1);
        bus(0, 4'h6, 0);
        chk(rdat[0], 1);
        fwd_req <= 0;
        rev_req <= 1;
        repeat (6) @(posedge clk);
        bus(0, 4'h5, 0);
        chk(rdat[2], 1);
        rev_req <= 0;
        repeat (6) @(posedge clk);
        bus(0, 4'h5, 0);
        chk(rdat[2], 0);
        bus(1, 4'h6, 32'h0000_000F);
        bus(1, 4'h0, 32'h0000_0034);
        run_to(25);
        cur <= 9'h078;
        repeat (10) @(posedge clk);
        chk(khz, 32'h0000_0019);
        cur <= 9'h064;
        repeat (10) @(posedge clk);
        chk(khz, 32'h0000_0064);
        press;
        repeat (20) @(posedge clk);
        chk(on, 1);
        bus(0, 4'h6, 0);
        chk(rdat, 32'h0000_0008);
        fwd_req <= 0;
        bus(1, 4'h0, 32'h0000_0183);
        while (fout !== 25)
            @(posedge clk);
        press;
        repeat (30) @(posedge clk);
        bus(0, 4'h5, 0);
        chk(rdat[3:2], 2'b11);
        bus(1, 4'h0, 32'h0000_0083);
        repeat (2) @(posedge clk);
        bus(0, 4'h5, 0);
        chk(rdat[2], 0);
        do_reset(0);
        chk(khz, 32'h0000_004B);
        final_report;
    end
endmodule
